// ---- cdx_exec_unit.sv ----
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module cdx_exec_unit #(
    parameter int STACK_DEPTH = 16
) (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire cdx_pkg::cdx_apb_req_t apbReq,
    output cdx_pkg::cdx_apb_rsp_t      apbRsp,
    output cdx_pkg::cdx_wdt_t          wdtClear
);

    localparam int SP_W = $clog2(STACK_DEPTH);

    typedef struct packed {
        cdx_pkg::cdx_state_t             st;
        logic [13:0]                     instr;
        logic                            skipPending;
        logic [7:0]                      acc;
        logic [6:0]                      pcLatch;
        logic [14:0]                     pc;
        logic                            zero;
        logic                            toN;
        logic                            pdN;
        logic [SP_W-1:0]                 sp;
        logic [STACK_DEPTH-1:0][14:0]    stack;
        logic [127:0][7:0]               fileMem;
        logic [31:0]                     cycles;
        cdx_pkg::cdx_wdt_t               wdt;
        cdx_pkg::cdx_apb_rsp_t           rsp;
    } cdx_state_reg_t;

    cdx_state_reg_t s_reg;
    cdx_state_reg_t s_next;

    function automatic logic opIs(input logic [13:0] ins, input logic [13:0] mask,
                                  input logic [13:0] val);
        opIs = (ins & mask) == val;
    endfunction

    function automatic logic isFileAddr(input logic [11:0] addr);
        isFileAddr = (addr[11:9] == cdx_pkg::FILE_BASE) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic isRegAddr(input logic [11:0] addr);
        isRegAddr = (addr == cdx_pkg::OFF_INSTR) || (addr == cdx_pkg::OFF_STATUS)
                 || (addr == cdx_pkg::OFF_ACC) || (addr == cdx_pkg::OFF_PCLAT)
                 || (addr == cdx_pkg::OFF_PC) || (addr == cdx_pkg::OFF_SP)
                 || (addr == cdx_pkg::OFF_STKTOP) || (addr == cdx_pkg::OFF_CYCLES);
    endfunction

    always_comb begin
        logic [6:0]  fAddr;
        logic        toReg;
        logic [7:0]  operand;
        logic [7:0]  result;
        logic        writeBack;
        logic        apbAccess;
        logic [31:0] rd;
        logic [SP_W-1:0] topIdx;
        fAddr     = s_reg.instr[6:0];
        toReg     = s_reg.instr[cdx_pkg::DEST_BIT];
        operand   = s_reg.fileMem[fAddr];
        result    = 8'h00;
        writeBack = 1'b0;
        apbAccess = apbReq.psel && apbReq.penable;
        rd        = 32'h0000_0000;
        topIdx    = s_reg.sp - SP_W'(1);
        s_next    = s_reg;
        s_next.wdt = '0;

        case (s_reg.st)
            cdx_pkg::ST_IDLE: begin
                s_next.st = cdx_pkg::ST_IDLE;
            end
            cdx_pkg::ST_EXEC: begin
                s_next.st     = cdx_pkg::ST_IDLE;
                s_next.cycles = s_reg.cycles + 32'h0000_0001;
                s_next.pc     = s_reg.pc + 15'h0001;
                if (s_reg.skipPending) begin
                    // Fetched instruction dropped, runs as no_operation
                    s_next.skipPending = 1'b0;
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_FULL,
                                  cdx_pkg::OP_WDT_CLEAR)) begin
                    s_next.wdt.countClear    = 1'b1;
                    s_next.wdt.prescaleClear = 1'b1;
                    s_next.toN = 1'b1;
                    s_next.pdN = 1'b1;
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_FULL,
                                  cdx_pkg::OP_ACC_CALL)) begin
                    s_next.stack[s_reg.sp] = s_reg.pc + 15'h0001;
                    s_next.sp = s_reg.sp + SP_W'(1);
                    s_next.pc = {s_reg.pcLatch, s_reg.acc};
                    s_next.st = cdx_pkg::ST_SECOND;
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_CALL,
                                  cdx_pkg::OP_CALL)) begin
                    s_next.stack[s_reg.sp] = s_reg.pc + 15'h0001;
                    s_next.sp = s_reg.sp + SP_W'(1);
                    s_next.pc = {s_reg.pcLatch[6:3], s_reg.instr[10:0]};
                    s_next.st = cdx_pkg::ST_SECOND;
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_F_DEST,
                                  cdx_pkg::OP_COMPLEMENT)) begin
                    result      = ~operand;
                    writeBack   = 1'b1;
                    s_next.zero = (result == 8'h00);
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_F_ONLY,
                                  cdx_pkg::OP_REG_CLEAR)) begin
                    s_next.fileMem[fAddr] = 8'h00;
                    s_next.zero = 1'b1;
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_F_ONLY,
                                  cdx_pkg::OP_ACC_CLEAR)) begin
                    s_next.acc  = 8'h00;
                    s_next.zero = 1'b1;
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_F_DEST,
                                  cdx_pkg::OP_DECREMENT)) begin
                    result      = operand - 8'h01;
                    writeBack   = 1'b1;
                    s_next.zero = (result == 8'h00);
                end else if (opIs(s_reg.instr, cdx_pkg::MASK_F_DEST,
                                  cdx_pkg::OP_DEC_SKIP_ZERO)) begin
                    result    = operand - 8'h01;
                    writeBack = 1'b1;
                    s_next.skipPending = (result == 8'h00);
                end
                if (writeBack) begin
                    if (toReg) begin
                        s_next.fileMem[fAddr] = result;
                    end else begin
                        s_next.acc = result;
                    end
                end
            end
            cdx_pkg::ST_SECOND: begin
                // Second cycle of a call, flags untouched
                s_next.cycles = s_reg.cycles + 32'h0000_0001;
                s_next.st     = cdx_pkg::ST_IDLE;
            end
            default: begin
                s_next.st = cdx_pkg::ST_IDLE;
            end
        endcase

        // APB slave: one wait state, response from flops
        if (apbAccess && !s_reg.rsp.pready) begin
            s_next.rsp.pready  = 1'b1;
            s_next.rsp.pslverr = 1'b0;
            if (isFileAddr(apbReq.paddr)) begin
                rd = {24'h000000, s_reg.fileMem[apbReq.paddr[8:2]]};
            end else if (!isRegAddr(apbReq.paddr)) begin
                s_next.rsp.pslverr = 1'b1;
            end else if (apbReq.pwrite && (s_reg.st != cdx_pkg::ST_IDLE)
                         && (apbReq.paddr != cdx_pkg::OFF_CYCLES)) begin
                // Register writes other than to OFF_CYCLES refused while an instruction runs
                s_next.rsp.pslverr = 1'b1;
            end else begin
                case (apbReq.paddr)
                    cdx_pkg::OFF_INSTR:  rd = {18'h00000, s_reg.instr};
                    cdx_pkg::OFF_STATUS: begin
                        rd[cdx_pkg::ST_BUSY_BIT] = (s_reg.st != cdx_pkg::ST_IDLE);
                        rd[cdx_pkg::ST_SKIP_BIT] = s_reg.skipPending;
                        rd[cdx_pkg::ST_ZERO_BIT] = s_reg.zero;
                        rd[cdx_pkg::ST_PDN_BIT]  = s_reg.pdN;
                        rd[cdx_pkg::ST_TON_BIT]  = s_reg.toN;
                    end
                    cdx_pkg::OFF_ACC:    rd = {24'h000000, s_reg.acc};
                    cdx_pkg::OFF_PCLAT:  rd = {25'h0000000, s_reg.pcLatch};
                    cdx_pkg::OFF_PC:     rd = {17'h00000, s_reg.pc};
                    cdx_pkg::OFF_SP:     rd = 32'(s_reg.sp);
                    cdx_pkg::OFF_STKTOP: rd = {17'h00000, s_reg.stack[topIdx]};
                    cdx_pkg::OFF_CYCLES: rd = s_reg.cycles;
                    default:             rd = 32'h0000_0000;
                endcase
            end
            s_next.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rd;
        end else if (apbAccess && s_reg.rsp.pready) begin
            s_next.rsp.pready  = 1'b0;
            s_next.rsp.pslverr = 1'b0;
            if (apbReq.pwrite && !s_reg.rsp.pslverr) begin
                if (isFileAddr(apbReq.paddr)) begin
                    s_next.fileMem[apbReq.paddr[8:2]] = apbReq.pwdata[7:0];
                end else begin
                    case (apbReq.paddr)
                        cdx_pkg::OFF_INSTR: begin
                            s_next.instr = apbReq.pwdata[13:0];
                            s_next.st    = cdx_pkg::ST_EXEC;
                        end
                        cdx_pkg::OFF_STATUS: begin
                            s_next.zero = apbReq.pwdata[cdx_pkg::ST_ZERO_BIT];
                            s_next.pdN  = apbReq.pwdata[cdx_pkg::ST_PDN_BIT];
                            s_next.toN  = apbReq.pwdata[cdx_pkg::ST_TON_BIT];
                        end
                        cdx_pkg::OFF_ACC:    s_next.acc     = apbReq.pwdata[7:0];
                        cdx_pkg::OFF_PCLAT:  s_next.pcLatch = apbReq.pwdata[6:0];
                        cdx_pkg::OFF_PC:     s_next.pc      = apbReq.pwdata[14:0];
                        cdx_pkg::OFF_SP:     s_next.sp      = apbReq.pwdata[SP_W-1:0];
                        default: begin
                            s_next.sp = s_next.sp;
                        end
                    endcase
                end
            end
        end else begin
            s_next.rsp.pready  = 1'b0;
            s_next.rsp.pslverr = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg             <= '0;
            s_reg.st          <= cdx_pkg::ST_IDLE;
            s_reg.instr       <= cdx_pkg::INSTR_RST;
            s_reg.acc         <= cdx_pkg::ACC_RST;
            s_reg.pc          <= cdx_pkg::PC_RST;
            s_reg.toN         <= cdx_pkg::TON_RST;
            s_reg.pdN         <= cdx_pkg::PDN_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign apbRsp   = s_reg.rsp;
    assign wdtClear = s_reg.wdt;

endmodule

// ---- cdx_pkg.sv ----
package cdx_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_INSTR  = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_ACC    = 12'h008;
    localparam logic [11:0] OFF_PCLAT  = 12'h00C;
    localparam logic [11:0] OFF_PC     = 12'h010;
    localparam logic [11:0] OFF_SP     = 12'h014;
    localparam logic [11:0] OFF_STKTOP = 12'h018;
    localparam logic [11:0] OFF_CYCLES = 12'h01C;
    localparam logic [2:0]  FILE_BASE  = 3'h1;     // paddr[11:9], window 0x200..0x3FC

    // Status register bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SKIP_BIT = 1;
    localparam int ST_ZERO_BIT = 2;
    localparam int ST_PDN_BIT  = 3;
    localparam int ST_TON_BIT  = 4;

    // Reset values
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [14:0] PC_RST   = 15'h0000;
    localparam logic        TON_RST  = 1'b1;
    localparam logic        PDN_RST  = 1'b1;
    localparam logic [13:0] INSTR_RST = 14'h0000;

    // Instruction encodings: value and mask
    localparam logic [13:0] OP_NO_OPERATION  = 14'h0000;
    localparam logic [13:0] OP_WDT_CLEAR     = 14'h0064;
    localparam logic [13:0] OP_ACC_CALL      = 14'h000A;
    localparam logic [13:0] OP_REG_CLEAR     = 14'h0180;
    localparam logic [13:0] OP_ACC_CLEAR     = 14'h0100;
    localparam logic [13:0] OP_COMPLEMENT    = 14'h0900;
    localparam logic [13:0] OP_DECREMENT     = 14'h0300;
    localparam logic [13:0] OP_DEC_SKIP_ZERO = 14'h0B00;
    localparam logic [13:0] OP_CALL          = 14'h2000;
    localparam logic [13:0] MASK_FULL        = 14'h3FFF;
    localparam logic [13:0] MASK_F_ONLY      = 14'h3F80;
    localparam logic [13:0] MASK_F_DEST      = 14'h3F00;
    localparam logic [13:0] MASK_CALL        = 14'h3800;
    localparam int          DEST_BIT         = 7;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} cdx_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cdx_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cdx_apb_rsp_t;

    typedef struct packed {
        logic countClear;
        logic prescaleClear;
    } cdx_wdt_t;

endpackage

// ---- cdx_exec_monitor.sv ----
`timescale 1ns/10ps
module cdx_exec_monitor (
    input wire logic                  ref_clk,
    input wire logic                  nrst,
    input wire cdx_pkg::cdx_apb_req_t apbReq,
    input wire cdx_pkg::cdx_apb_rsp_t apbRsp,
    input wire cdx_pkg::cdx_wdt_t     wdtClear
);
    logic acc;
    logic wdtWr;
    logic inFile;
    assign acc = apbReq.psel && apbReq.penable;
    assign inFile = apbReq.paddr[11:9] == cdx_pkg::FILE_BASE;
    assign wdtWr = acc && apbRsp.pready && !apbRsp.pslverr && apbReq.pwrite
        && apbReq.paddr == cdx_pkg::OFF_INSTR
        && apbReq.pwdata[13:0] == cdx_pkg::OP_WDT_CLEAR;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_wdt_pair: assert property (wdtClear.countClear == wdtClear.prescaleClear)
        else $error("clear pulses differ");
    a_wdt_single: assert property (wdtClear.countClear |=> !wdtClear.countClear)
        else $error("clear pulse too long");
    a_wdt_cause: assert property (wdtClear.countClear |-> $past(wdtWr, 2))
        else $error("clear pulse without clear op");
    a_ready_wait: assert property (acc && !apbRsp.pready |=> apbRsp.pready)
        else $error("ready late");
    a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready held");
    a_ready_access: assert property (apbRsp.pready |-> acc)
        else $error("ready outside access");
    a_file_misalign: assert property (acc && apbRsp.pready && inFile
        && apbReq.paddr[1:0] != 2'h0 |-> apbRsp.pslverr) else $error("misaligned taken");
    a_file_aligned: assert property (acc && apbRsp.pready && inFile
        && apbReq.paddr[1:0] == 2'h0 |-> !apbRsp.pslverr) else $error("file refused");
    a_write_data: assert property (apbRsp.pready && apbReq.pwrite |-> apbRsp.prdata == 32'h0)
        else $error("read data on write");
endmodule

// ---- tb_cpu_clear_decrement_call_exec.sv ----
`timescale 1ns/10ps
module tb_cpu_clear_decrement_call_exec;
    logic                  ref_clk;
    logic                  nrst;
    cdx_pkg::cdx_apb_req_t apbReq;
    cdx_pkg::cdx_apb_rsp_t apbRsp;
    cdx_pkg::cdx_wdt_t     wdtClear;
    int                    miscompares = 0;
    int                    total_checks = 0;
    int                    pulses = 0;
    logic [31:0]           rdData;
    logic                  rdErr;
    logic [31:0]           base;

    cdx_exec_unit dut (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .apbReq  (apbReq),
        .apbRsp  (apbRsp),
        .wdtClear(wdtClear)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (wdtClear.countClear === 1'b1) pulses <= pulses + 1;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        // Ready and data are taken at the rising edge that completes the access
        @(posedge ref_clk);
        while (apbRsp.pready !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20) miscompares++;
        rdData = apbRsp.prdata;
        rdErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", {31'h0, rdErr}, 32'h0);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic issue(input logic [13:0] op);
        int n;
        n = 0;
        wr(cdx_pkg::OFF_INSTR, {18'h0, op});
        rd(cdx_pkg::OFF_STATUS);
        while (rdData[cdx_pkg::ST_BUSY_BIT] !== 1'b0 && n < 10) begin
            rd(cdx_pkg::OFF_STATUS);
            n++;
        end
    endtask

    task automatic test_wdt;
        int p;
        rd(cdx_pkg::OFF_STATUS);
        chk("reset status", rdData, 32'h18);
        wr(cdx_pkg::OFF_STATUS, 32'h04);
        p = pulses;
        issue(cdx_pkg::OP_WDT_CLEAR);
        chk("clear pulses", 32'(pulses - p), 32'h1);
        rd(cdx_pkg::OFF_STATUS);
        chk("status", rdData, 32'h1C);
        $display("test watchdog clear done");
    endtask

    task automatic call_case(input logic [13:0] op, input logic [6:0] lat, input logic [31:0] pc);
        wr(cdx_pkg::OFF_ACC, 32'h5A);
        wr(cdx_pkg::OFF_PCLAT, {25'h0, lat});
        wr(cdx_pkg::OFF_PC, 32'h1234);
        wr(cdx_pkg::OFF_SP, 32'h0);
        rd(cdx_pkg::OFF_CYCLES);
        base = rdData;
        issue(op);
        rd(cdx_pkg::OFF_STKTOP);
        chk("stack top", rdData, 32'h1235);
        rd(cdx_pkg::OFF_SP);
        chk("stack ptr", rdData, 32'h1);
        rd(cdx_pkg::OFF_PC);
        chk("pc", rdData, pc);
        rd(cdx_pkg::OFF_CYCLES);
        chk("cycles", rdData - base, 32'h2);
        rd(cdx_pkg::OFF_STATUS);
        chk("status", rdData, 32'h1C);
        $display("test call %h done", op);
    endtask

    task automatic alu_case(input logic [13:0] op, input logic [7:0] v, input logic [7:0] a,
                            input logic [7:0] f, input logic [7:0] st);
        wr({cdx_pkg::FILE_BASE, 9'h1FC}, {24'h0, v});
        wr(cdx_pkg::OFF_ACC, 32'h77);
        wr(cdx_pkg::OFF_STATUS, 32'h0);
        issue(op | 14'h007F);
        rd(cdx_pkg::OFF_ACC);
        chk("acc", rdData, {24'h0, a});
        rd({cdx_pkg::FILE_BASE, 9'h1FC});
        chk("file", rdData, {24'h0, f});
        rd(cdx_pkg::OFF_STATUS);
        chk("status", rdData, {24'h0, st});
        $display("test op %h done", op);
    endtask

    task automatic test_skip;
        rd(cdx_pkg::OFF_CYCLES);
        base = rdData;
        issue(cdx_pkg::OP_ACC_CLEAR);
        rd(cdx_pkg::OFF_ACC);
        chk("acc", rdData, 32'h77);
        rd(cdx_pkg::OFF_STATUS);
        chk("status", rdData, 32'h0);
        rd(cdx_pkg::OFF_CYCLES);
        chk("cycles", rdData - base, 32'h1);
        issue(cdx_pkg::OP_ACC_CLEAR);
        rd(cdx_pkg::OFF_ACC);
        chk("acc", rdData, 32'h0);
        rd(12'h020);
        chk("unmapped", {31'h0, rdErr}, 32'h1);
        rd(12'h201);
        chk("misaligned", {31'h0, rdErr}, 32'h1);
        $display("test skip done");
    endtask

    initial begin
        apbReq = '0;
        nrst = 1'b0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        test_wdt;
        call_case(cdx_pkg::OP_ACC_CALL, 7'h35, 32'h355A);
        call_case(cdx_pkg::OP_CALL | 14'h0123, 7'h55, 32'h5123);
        alu_case(14'h0900, 8'hFF, 8'h00, 8'hFF, 8'h04);
        alu_case(14'h0980, 8'h0F, 8'h77, 8'hF0, 8'h00);
        alu_case(14'h0380, 8'h01, 8'h77, 8'h00, 8'h04);
        alu_case(14'h0300, 8'h00, 8'hFF, 8'h00, 8'h00);
        alu_case(14'h0180, 8'h33, 8'h77, 8'h00, 8'h04);
        alu_case(14'h0100, 8'h33, 8'h00, 8'h33, 8'h04);
        alu_case(14'h0B00, 8'h03, 8'h02, 8'h03, 8'h00);
        alu_case(14'h0B80, 8'h01, 8'h77, 8'h00, 8'h02);
        test_skip;
        report_and_stop;
    end

    initial begin
        #1000000;
        miscompares++;
        report_and_stop;
    end
endmodule

bind cdx_exec_unit cdx_exec_monitor mon (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .apbReq  (apbReq),
    .apbRsp  (apbRsp),
    .wdtClear(wdtClear)
);
